//--- rtl/pig_periodic_irq.sv
// Periodic interrupt generator: sub-second divider, pulse and level modes,
// oscillation adjustment, Avalon-MM register slave and core interrupt.
// Assumes same-clock calendar hints and alarm level; the open-drain pin is
// resolved outside from the output enable.
`timescale 1ns/1ns

// Function
// [R1] Selection codes: off, low, 2 Hz, 1 Hz
// [R2] Pulse waves have about fifty percent duty
// [R3] Level mode holds low until flag cleared
// [R4] Level periods: second, minute, hour, month
// [R5] Month period fires on day one midnight
// [R6] Pulse waves locked to second increment
// [R7] Second increments 92 us after fall
// [R8] Seconds write clears divider, pulse goes low
// [R9] Level fall coincides with second increment
// [R10] Adjustment every twenty seconds bends pulse low
// [R11] Level second period shifts at most 3.784 ms
// [R12] Output low when periodic or alarm active
// [R13] Flag in CTRL2 bit 2; zero disables
// [R14] Selection resets to off
module pig_periodic_irq
    import pig_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire pig_pkg::pig_avm_req_t i_avm,
    output logic [31:0] o_avm_readdata,
    output logic o_avm_waitrequest,
    input wire logic i_sec_write,
    input wire pig_pkg::pig_cal_t i_cal,
    input wire logic i_alarm_active,
    output logic o_sec_inc,
    output logic o_irq_out_n_o,
    output logic o_irq_out_n_oe,
    output logic o_irq
);
    import pig_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [11:0] div_r, div_nxt;          // Core cycles toward next timebase tick
    logic tick;                           // One-cycle timebase enable
    logic [14:0] sub_r, sub_nxt;          // Sub-second divider stages
    logic [4:0] adj_sec_r, adj_sec_nxt;   // Seconds since last correction
    logic [6:0] hold_r, hold_nxt;         // Ticks left to stall the divider
    logic sec_inc_r, sec_inc_nxt;         // Seconds counter increment strobe
    logic sec_inc_now;                    // Increment happens on this tick
    pig_sel_t sel_r, sel_nxt;             // Period selection field
    logic flag_r, flag_nxt;               // periodic_irq_flag
    logic [7:0] adj_r, adj_nxt;           // Adjust enable and signed amount
    logic [1:0] stat_r, stat_nxt;         // Sticky events
    logic [1:0] mask_r, mask_nxt;         // Event mask
    logic ack_r, ack_nxt;                 // Bus answer cycle
    logic [31:0] rdata_r, rdata_nxt;      // Registered read data
    logic oe_r, oe_nxt;                   // Pin pulled low
    logic irq_r, irq_nxt;                 // Core interrupt level
    logic period_hit;                     // Selected level period elapses
    logic per_low;                        // Periodic source wants the pin low
    logic wr_take;                        // Write takes effect this edge
    logic [6:0] adj_mag;                  // Clamped correction size

    // Signed correction magnitude, clamped to the largest legal step
    function automatic logic [6:0] adj_size(input logic [6:0] v);
        logic [6:0] m;
        m = v[6] ? 7'(-v) : v;
        adj_size = (m > ADJ_MAX_TICKS) ? ADJ_MAX_TICKS : m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Timebase tick divider
    always_comb
    begin
        tick = (div_r == 12'(TICK_CYC - 1));
        if (i_sec_write)
        begin
            // A seconds rewrite restarts the whole chain, the core-rate stage too,
            // so the next increment lands a whole number of ticks after the write
            div_nxt = 12'h000; // [R8]
        end
        else if (tick)
        begin
            div_nxt = 12'h000;
        end
        else
        begin
            div_nxt = div_r + 12'h001;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            div_r <= 12'h000;
        end
        else
        begin
            div_r <= div_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sub-second divider with oscillation adjustment
    always_comb
    begin
        adj_mag = adj_size(adj_r[6:0]);
        sub_nxt = sub_r;
        adj_sec_nxt = adj_sec_r;
        hold_nxt = hold_r;
        // Seconds counter steps a fixed delay after the divider wraps; the step lands
        // on the tick that brings the divider up to the delay count, not one tick later
        sec_inc_now = tick && (sub_r == SEC_INC_TICK - 15'h0001) && (hold_r == 7'h00); // [R7] [R6]
        sec_inc_nxt = sec_inc_now;
        if (i_sec_write)
        begin
            // Clearing every stage restarts the wave at its falling edge
            sub_nxt = 15'h0000; // [R8]
            hold_nxt = 7'h00;
        end
        else if (tick)
        begin
            if (hold_r != 7'h00)
            begin
                // Stalling inside the low phase stretches it
                hold_nxt = hold_r - 7'h01; // [R10]
            end
            else if (sub_r == ADJ_POINT && adj_r[FLD_ADJ_EN] && adj_sec_r == 5'h00)
            begin
                // Once per correction window bend the current second
                if (adj_r[6])
                begin
                    hold_nxt = adj_mag; // [R10] [R11]
                    sub_nxt = sub_r + 15'h0001;
                end
                else
                begin
                    sub_nxt = sub_r + 15'h0001 + 15'(adj_mag); // [R10] [R11]
                end
            end
            else
            begin
                sub_nxt = sub_r + 15'h0001;
            end
            if (sec_inc_now)
            begin
                adj_sec_nxt = (adj_sec_r == ADJ_PERIOD_SEC - 5'h01) ? 5'h00 : adj_sec_r + 5'h01; // [R10]
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sub_r <= 15'h0000;
            adj_sec_r <= 5'h00;
            hold_r <= 7'h00;
            sec_inc_r <= 1'b0;
        end
        else
        begin
            sub_r <= sub_nxt;
            adj_sec_r <= adj_sec_nxt;
            hold_r <= hold_nxt;
            sec_inc_r <= sec_inc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Period decode and pin level
    always_comb
    begin
        // Level periods fire with the increment that rolls the counters
        unique case (sel_r)
            SEL_SEC:   period_hit = sec_inc_now; // [R4] [R9]
            SEL_MIN:   period_hit = sec_inc_now && i_cal.wrap_min; // [R4]
            SEL_HOUR:  period_hit = sec_inc_now && i_cal.wrap_hour; // [R4]
            SEL_MONTH: period_hit = sec_inc_now && i_cal.wrap_month; // [R5]
            SEL_OFF, SEL_LOW, SEL_2HZ, SEL_1HZ: period_hit = 1'b0;
        endcase
        unique case (sel_r)
            SEL_OFF: per_low = 1'b0; // [R1] [R13]
            SEL_LOW: per_low = 1'b1; // [R1]
            // Low for the first half of each half second
            SEL_2HZ: per_low = ((sub_r & QUARTER_BIT) == 15'h0000); // [R1] [R2] [R6]
            // Low for the first half second
            SEL_1HZ: per_low = (sub_r < HALF_SEC_BIT); // [R1] [R2] [R6]
            SEL_SEC, SEL_MIN, SEL_HOUR, SEL_MONTH: per_low = flag_r; // [R3]
        endcase
        // Open drain: both sources pull the same pin low
        oe_nxt = per_low || i_alarm_active; // [R12]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file, events and interrupt
    always_comb
    begin
        wr_take = i_avm.write && ack_r && i_avm.byteenable[0];
        sel_nxt = sel_r;
        flag_nxt = flag_r;
        adj_nxt = adj_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        if (wr_take)
        begin
            unique case (i_avm.address)
                OFS_CTRL1: sel_nxt = pig_sel_t'(i_avm.writedata[FLD_SEL_LSB +: 3]);
                // Writing zero releases the pin; writing one has no effect
                OFS_CTRL2: if (!i_avm.writedata[FLD_FLAG]) flag_nxt = 1'b0; // [R3]
                OFS_ADJ: adj_nxt = i_avm.writedata[7:0];
                OFS_IRQ_STAT: stat_nxt = stat_r & ~i_avm.writedata[1:0];
                OFS_IRQ_MASK: mask_nxt = i_avm.writedata[1:0];
                default: ;
            endcase
        end
        // Hardware set wins over a CTRL2 clear in the same cycle
        if (period_hit)
        begin
            flag_nxt = 1'b1; // [R3] [R13]
        end
        if (sec_inc_now)
        begin
            stat_nxt[EVT_SEC] = 1'b1;
        end
        if (period_hit && !flag_r)
        begin
            stat_nxt[EVT_FLAG] = 1'b1;
        end
        // Leaving level mode drops a stale flag so the pin cannot stick
        if (!sel_nxt[2])
        begin
            flag_nxt = 1'b0;
        end
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sel_r <= pig_sel_t'(RST_SEL); // [R14]
            flag_r <= 1'b0;
            adj_r <= RST_ADJ;
            mask_r <= RST_MASK;
            stat_r <= 2'h0;
            oe_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            sel_r <= sel_nxt;
            flag_r <= flag_nxt;
            adj_r <= adj_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            oe_r <= oe_nxt;
            irq_r <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle on every access
    always_comb
    begin
        ack_nxt = (i_avm.read || i_avm.write) && !ack_r;
        rdata_nxt = rdata_r;
        if (i_avm.read && !ack_r)
        begin
            unique case (i_avm.address)
                OFS_CTRL1: rdata_nxt = {29'h0, sel_r};
                OFS_CTRL2: rdata_nxt = {29'h0, flag_r, 2'h0}; // [R13]
                OFS_ADJ: rdata_nxt = {24'h0, adj_r};
                OFS_IRQ_STAT: rdata_nxt = {30'h0, stat_r};
                OFS_IRQ_MASK: rdata_nxt = {30'h0, mask_r};
                OFS_TIMEBASE: rdata_nxt = {17'h0, sub_r};
                // Unmapped addresses read as zero
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_avm_waitrequest = (i_avm.read || i_avm.write) && !ack_r;
    assign o_avm_readdata = rdata_r;
    assign o_sec_inc = sec_inc_r;
    assign o_irq_out_n_o = 1'b0;   // Open drain only ever pulls low
    assign o_irq_out_n_oe = oe_r;  // [R12]
    assign o_irq = irq_r;

endmodule

//--- rtl/pig_pkg.sv
// Package for the periodic interrupt generator of the real-time clock.
// Assumes a 100 MHz core clock and an Avalon-MM master with 32-bit data.
package pig_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock rates and timing
    localparam int CORE_HZ = 100_000_000;        // Core clock rate
    localparam int TIMEBASE_HZ = 32768;          // Timekeeping divider rate
    localparam int TICK_CYC = CORE_HZ / TIMEBASE_HZ; // Core cycles per timebase tick
    localparam int SEC_INC_DELAY_NS = 92_000;    // Pulse fall to second increment
    localparam logic [14:0] SEC_INC_TICK = 15'((SEC_INC_DELAY_NS * 64'd32768) / 64'd1_000_000_000);
    localparam int ADJ_MAX_NS = 3_784_000;       // Largest correction per event
    localparam logic [6:0] ADJ_MAX_TICKS = 7'((ADJ_MAX_NS * 64'd32768) / 64'd1_000_000_000);
    localparam logic [4:0] ADJ_PERIOD_SEC = 5'd20; // Seconds between corrections
    localparam logic [14:0] ADJ_POINT = 15'h1000; // Tick inside the 1 Hz low phase and the first 2 Hz low phase
    localparam logic [14:0] HALF_SEC_BIT = 15'h4000; // 1 Hz wave is low below this
    localparam logic [14:0] QUARTER_BIT = 15'h2000;  // 2 Hz wave is low while this bit is clear

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [5:0] OFS_CTRL1 = 6'h00;    // Period selection
    localparam logic [5:0] OFS_CTRL2 = 6'h04;    // Periodic interrupt flag
    localparam logic [5:0] OFS_ADJ = 6'h08;      // Oscillation adjustment
    localparam logic [5:0] OFS_IRQ_STAT = 6'h0c; // Sticky event bits, write one to clear
    localparam logic [5:0] OFS_IRQ_MASK = 6'h10; // Event mask
    localparam logic [5:0] OFS_TIMEBASE = 6'h14; // Sub-second counter, read only

    // Field positions
    localparam int FLD_SEL_LSB = 0;              // CTRL1 selection field [2:0]
    localparam int FLD_FLAG = 2;                 // CTRL2 periodic_irq_flag
    localparam int FLD_ADJ_EN = 7;               // ADJ enable, value in [6:0]
    localparam int EVT_SEC = 0;                  // Event: seconds counter increment
    localparam int EVT_FLAG = 1;                 // Event: periodic flag raised

    // Reset values
    localparam logic [2:0] RST_SEL = 3'h0;
    localparam logic [7:0] RST_ADJ = 8'h00;
    localparam logic [1:0] RST_MASK = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Period selection codes
    typedef enum logic [2:0] {
        SEL_OFF = 3'b000,
        SEL_LOW = 3'b001,
        SEL_2HZ = 3'b010,
        SEL_1HZ = 3'b011,
        SEL_SEC = 3'b100,
        SEL_MIN = 3'b101,
        SEL_HOUR = 3'b110,
        SEL_MONTH = 3'b111
    } pig_sel_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } pig_avm_req_t;

    // Calendar rollover hints from the counters
    typedef struct packed {
        logic wrap_min;    // Next increment brings seconds to 00
        logic wrap_hour;   // Next increment brings minutes and seconds to 00
        logic wrap_month;  // Next increment lands on day 1, 00:00:00
    } pig_cal_t;

endpackage

//--- test/pig_host_model.sv
// Host end of the interrupt line: pull-up and a count of falls.
// Assumes the device only ever sinks the pin.
`timescale 1ns/1ns
module pig_host_model
(
    input wire logic i_irq_out_n_o,
    input wire logic i_irq_out_n_oe,
    output logic o_pin,
    output logic [15:0] o_fall_cnt
);
    logic [15:0] falls_r = 16'h0000; // Falls seen so far, one driver only
    // Released line floats up through the resistor
    assign o_pin = i_irq_out_n_oe ? i_irq_out_n_o : 1'b1;
    // Each fall is one interrupt seen by the host
    always @(negedge o_pin) falls_r <= falls_r + 16'h0001;
    assign o_fall_cnt = falls_r;
endmodule

//--- test/pig_irq_asserts.sv
// Port checker for the periodic interrupt generator.
// Assumes bus masters hold each request until waitrequest is low.
`timescale 1ns/1ns
module pig_irq_asserts
    import pig_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire pig_pkg::pig_avm_req_t i_avm,
    input wire logic [31:0] o_avm_readdata,
    input wire logic o_avm_waitrequest,
    input wire logic i_sec_write,
    input wire logic i_alarm_active,
    input wire logic o_sec_inc,
    input wire logic o_irq_out_n_o,
    input wire logic o_irq_out_n_oe,
    input wire logic o_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////////////////
    // Cycles since the last seconds rewrite; saturates so stale rewrites stop counting
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    // Next count
    always_comb
    begin
        cnt_nxt = i_sec_write ? 16'h0000 : ((cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h0001);
    end
    // Count register
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cnt_r <= 16'hffff;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    chk_bus_one_wait: assert property (
        (i_avm.read || i_avm.write) && o_avm_waitrequest |=> !o_avm_waitrequest)
        else $error("bus answer late");
    chk_read_stands: assert property (!(i_avm.read && o_avm_waitrequest) |=> $stable(o_avm_readdata))
        else $error("read data moved");
    chk_pin_only_low: assert property (o_irq_out_n_o == 1'b0)
        else $error("pin data not low");
    chk_alarm_pulls: assert property (i_alarm_active |-> ##[1:2] o_irq_out_n_oe)
        else $error("alarm did not pull pin");
    chk_inc_single: assert property (o_sec_inc |=> !o_sec_inc)
        else $error("increment strobe too long");
    // Increment comes about 92 us, 9000 to 9400 core cycles, after a rewrite restarts the chain
    chk_inc_delay: assert property (
        o_sec_inc && cnt_r != 16'hffff |-> cnt_r >= 16'd9000 && cnt_r <= 16'd9400)
        else $error("increment off after rewrite");
    chk_irq_rise: assert property (
        $rose(o_irq) |-> o_sec_inc || $past(o_sec_inc) || $past(o_sec_inc, 2)
        || $past(o_sec_inc, 3) || $past(i_avm.write, 2) || $past(i_avm.write, 3))
        else $error("irq rose without cause");
    chk_irq_fall: assert property ($fell(o_irq) |-> $past(i_avm.write, 2) || $past(i_avm.write, 3))
        else $error("irq fell without write");
    // Main scenarios
    cov_inc: cover property (o_sec_inc);
    cov_irq: cover property ($rose(o_irq));
    cov_alarm: cover property (i_alarm_active && o_irq_out_n_oe);
endmodule
bind pig_periodic_irq pig_irq_asserts chk (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_avm(i_avm),
    .o_avm_readdata(o_avm_readdata), .o_avm_waitrequest(o_avm_waitrequest), .i_sec_write(i_sec_write),
    .i_alarm_active(i_alarm_active), .o_sec_inc(o_sec_inc), .o_irq_out_n_o(o_irq_out_n_o),
    .o_irq_out_n_oe(o_irq_out_n_oe), .o_irq(o_irq));

//--- test/tb.sv
// Bench for the periodic interrupt generator.
// Assumes the host model resolves the pin; seconds rewrites realign the divider.
`timescale 1ns/1ns
module tb;
    import pig_pkg::*;
    // Row: selection code and pin level just after a seconds rewrite
    typedef struct packed {logic [2:0] sel; logic pin;} pig_row_t;
    localparam pig_row_t ROWS [8] = '{'{3'h0, 1'b1}, '{3'h1, 1'b0}, '{3'h2, 1'b0}, '{3'h3, 1'b0},
        '{3'h4, 1'b1}, '{3'h5, 1'b1}, '{3'h6, 1'b1}, '{3'h7, 1'b1}};
    // Rollover hints that must not fire and that must fire
    localparam logic [2:0] BAD [3] = '{3'h0, 3'h4, 3'h6};
    localparam logic [2:0] GOOD [3] = '{3'h4, 3'h6, 3'h7};
    logic clk;
    logic rst;
    pig_avm_req_t avm;
    logic [31:0] rdata;
    logic wreq;
    logic sec_wr;
    pig_cal_t cal;
    logic alarm;
    logic sec_inc;
    logic od_o;
    logic od_oe;
    logic irq;
    logic pin;
    logic [15:0] falls;
    logic [15:0] f0;
    logic [31:0] q;
    int errors = 0;
    int cmp_count = 0;
    pig_periodic_irq dut (.i_core_clk(clk), .i_reset(rst), .i_avm(avm), .o_avm_readdata(rdata),
        .o_avm_waitrequest(wreq), .i_sec_write(sec_wr), .i_cal(cal), .i_alarm_active(alarm),
        .o_sec_inc(sec_inc), .o_irq_out_n_o(od_o), .o_irq_out_n_oe(od_oe), .o_irq(irq));
    pig_host_model host (.i_irq_out_n_o(od_o), .i_irq_out_n_oe(od_oe), .o_pin(pin), .o_fall_cnt(falls));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Compare seen against expected
    task automatic ck(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // One bus transfer; held until waitrequest is sampled low at a rising edge, data taken there
    task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avm <= '{read: rd, write: !rd, address: a, byteenable: 4'hf, writedata: d};
        do
        begin
            @(posedge clk);
        end
        while (wreq !== 1'b0);
        q = rdata;
        avm <= '0;
    endtask
    // Seconds rewrite strobe
    task automatic sec_pulse();
        @(posedge clk);
        sec_wr <= 1'b1;
        @(posedge clk);
        sec_wr <= 1'b0;
    endtask
    // Bounded wait for the increment strobe
    task automatic wait_inc();
        int n;
        n = 0;
        while (sec_inc !== 1'b1 && n < 15000)
        begin
            @(negedge clk);
            n++;
        end
        errors += int'(n == 15000);
    endtask
    // Let edges pass, then look where outputs are settled
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog sized well beyond the longest expected run
    initial
    begin
        repeat (95000) @(posedge clk);
        errors++;
        stop_test();
    end
    initial
    begin
        rst = 1'b1;
        avm = '0;
        sec_wr = 1'b0;
        cal = '0;
        alarm = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Every selection code from the table
        foreach (ROWS[i])
        begin
            bus(1'b0, OFS_CTRL1, 32'(ROWS[i].sel));
            sec_pulse();
            gap(3);
            ck(32'(pin), 32'(ROWS[i].pin));
            bus(1'b1, OFS_CTRL1, 32'h0);
            ck(32'(q[2:0]), 32'(ROWS[i].sel));
            // Rewrite cleared every divider stage, and no tick has come since
            bus(1'b1, OFS_TIMEBASE, 32'h0);
            ck(32'(q[14:0]), 32'h0);
        end
        // Level second: fall with the increment, held until the flag is cleared
        bus(1'b0, OFS_CTRL1, 32'(SEL_SEC));
        f0 = falls;
        sec_pulse();
        wait_inc();
        gap(2);
        ck(32'(pin), 32'h0);
        ck(32'(falls - f0), 32'h1);
        ck(32'(irq), 32'h0);
        bus(1'b1, OFS_CTRL2, 32'h0);
        ck(q & 32'h4, 32'h4);
        bus(1'b1, OFS_IRQ_STAT, 32'h0);
        ck(32'(q[1:0]), 32'h3);
        bus(1'b0, OFS_IRQ_MASK, 32'h1);
        gap(2);
        ck(32'(irq), 32'h1);
        bus(1'b0, OFS_IRQ_STAT, 32'h1);
        gap(2);
        ck(32'(irq), 32'h0);
        gap(6000);
        bus(1'b0, OFS_CTRL2, 32'h4);
        gap(2);
        ck(32'(pin), 32'h0);
        bus(1'b0, OFS_CTRL2, 32'h0);
        gap(2);
        ck(32'(pin), 32'h1);
        // Minute, hour and month fire only on their full rollover
        for (int m = 0; m < 6; m++)
        begin
            @(posedge clk);
            cal <= pig_cal_t'((m % 2) ? GOOD[m / 2] : BAD[m / 2]);
            bus(1'b0, OFS_CTRL1, 32'(5 + m / 2));
            bus(1'b0, OFS_CTRL2, 32'h0);
            sec_pulse();
            wait_inc();
            gap(2);
            ck(32'(pin), 32'(m % 2 == 0));
        end
        // Alarm shares the pin
        bus(1'b0, OFS_CTRL1, 32'(SEL_OFF));
        @(posedge clk);
        alarm <= 1'b1;
        gap(3);
        ck(32'(pin), 32'h0);
        @(posedge clk);
        alarm <= 1'b0;
        gap(3);
        ck(32'(pin), 32'h1);
        bus(1'b1, 6'h3c, 32'h0);
        ck(q, 32'h0);
        // Adjustment register keeps its enable and amount; its point is never reached here
        bus(1'b0, OFS_ADJ, 32'h85);
        bus(1'b1, OFS_ADJ, 32'h0);
        ck(q, 32'h85);
        // Second reset returns the selection to off
        bus(1'b0, OFS_CTRL1, 32'(SEL_LOW));
        @(posedge clk);
        rst <= 1'b1;
        gap(2);
        ck(32'(pin), 32'h1);
        @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, OFS_CTRL1, 32'h0);
        ck(q, 32'h0);
        stop_test();
    end
endmodule
